// ---- hdl/ucrm_pkg.sv ----
// ucrm_pkg: offsets, field positions and reset values of the channel register map.
// assumes a 4-bit location number and 8-bit registers.
package ucrm_pkg;
	localparam logic [3:0] ADDR_HOLD    = 4'h0;
	localparam logic [3:0] ADDR_IER     = 4'h1;
	localparam logic [3:0] ADDR_ISR     = 4'h2;
	localparam logic [3:0] ADDR_LCR     = 4'h3;
	localparam logic [3:0] ADDR_MCR     = 4'h4;
	localparam logic [3:0] ADDR_LSR     = 4'h5;
	localparam logic [3:0] ADDR_MSR     = 4'h6;
	localparam logic [3:0] ADDR_SPR     = 4'h7;
	localparam logic [3:0] ADDR_TX_FILL_COUNT   = 4'h8;
	localparam logic [3:0] ADDR_RX_FILL_COUNT   = 4'h9;
	localparam logic [3:0] ADDR_GPIO_DIRECTION   = 4'ha;
	localparam logic [3:0] ADDR_GPIO_PIN_STATE = 4'hb;
	localparam logic [3:0] ADDR_IOINT   = 4'hc;
	localparam logic [3:0] ADDR_RSVD    = 4'hd;
	localparam logic [3:0] ADDR_IOCTL   = 4'he;
	localparam logic [3:0] ADDR_EXTRA_FEATURES_CONTROL    = 4'hf;

	localparam logic [7:0] LCR_ENH_KEY  = 8'hbf;
	localparam int         LCR_DIV_BIT  = 7;
	localparam int         EFR_EXT_BIT  = 4;
	localparam int         MCR_TCR_BIT  = 2;
	localparam int         MCR_LOOP_BIT = 4;
	localparam int         FCR_EN_BIT   = 0;
	localparam int         FCR_RXR_BIT  = 1;
	localparam int         FCR_TXR_BIT  = 2;

	// writable masks: IER low nibble and MCR low five bits always, upper bits only with extended enable
	localparam logic [7:0] MASK_BASE_IER = 8'h0f;
	localparam logic [7:0] MASK_BASE_MCR = 8'h1f;
	localparam logic [7:0] MASK_EXT_IER  = 8'hf0;
	localparam logic [7:0] MASK_EXT_MCR  = 8'he0;
	localparam logic [7:0] MASK_EXT_ISR  = 8'h30;
	localparam logic [7:0] MASK_IOCTL    = 8'h0f;
	localparam logic [7:0] MASK_EXTRA_FEATURES_CONTROL     = 8'hb7;
	localparam logic [7:0] MASK_LVL      = 8'h7f;

	localparam logic [7:0] RST_REG      = 8'h00;
	localparam logic [7:0] RST_LCR      = 8'h1d;
	localparam logic [1:0] RST_TRIG     = 2'h0;
endpackage : ucrm_pkg

// ---- hdl/ucrm_sync.sv ----
// ucrm_sync: two-flop synchroniser for a bus of slow pin levels.
// assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
module ucrm_sync #(
	parameter int W = 12
) (
	// clock and reset
	input  wire logic         mclk_i,
	input  wire logic         resetn_i,
	// pin side
	input  wire logic [W-1:0] async_i,
	// synchronous side
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta;

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			// pins idle high; a zero reset would fake a change after reset
			meta   <= '1;
			sync_o <= '1;
		end else begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule // ucrm_sync

// ---- hdl/ucrm_regs.sv ----
// ucrm_regs: per-channel register map and bank decoder of a two-channel uart.
// assumes fifo, transmitter and receiver logic on mclk_i; modem and gpio pins asynchronous.
`timescale 1ns/1ps
module ucrm_regs (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// register port
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	// data path side
	input  wire logic [7:0] rx_data_i,
	output logic            rx_pop_o,
	output logic      [7:0] tx_data_o,
	output logic            tx_push_o,
	input  wire logic [6:0] tx_level_i,
	input  wire logic [6:0] rx_level_i,
	input  wire logic [3:0] int_code_i,
	input  wire logic [1:0] int_source_i,
	input  wire logic [7:0] line_status_i,
	// fifo control
	output logic            fifo_enable_o,
	output logic            rx_fifo_reset_o,
	output logic            tx_fifo_reset_o,
	output logic      [1:0] tx_trig_sel_o,
	output logic      [1:0] rx_trig_sel_o,
	// configuration
	output logic      [7:0] line_control_o,
	output logic     [15:0] divisor_o,
	output logic      [7:0] divisor_fraction_o,
	output logic      [7:0] enhanced_function_o,
	output logic      [7:0] interrupt_enable_o,
	output logic      [7:0] modem_control_o,
	output logic      [7:0] halt_resume_levels_o,
	output logic      [7:0] fifo_trigger_levels_o,
	output logic     [31:0] flow_chars_o,
	output logic      [7:0] gpio_irq_enable_o,
	output logic      [7:0] gpio_control_o,
	output logic      [7:0] extra_features_control_o,
	// modem pins, active low
	input  wire logic       cts_n_i,
	input  wire logic       dsr_n_i,
	input  wire logic       ri_n_i,
	input  wire logic       cd_n_i,
	output logic            dtr_n_o,
	output logic            rts_n_o,
	// gpio pins
	input  wire logic [7:0] gpio_i,
	output logic      [7:0] gpio_o,
	output logic      [7:0] gpio_oe_o
);
	logic [7:0]  line_control;
	logic [7:0]  enhanced_function;
	logic [7:0]  interrupt_enable;
	logic [7:0]  modem_control;
	logic [7:0]  dll;
	logic [7:0]  divisor_high;
	logic [7:0]  divisor_fraction;
	logic [7:0]  scratch_pad;
	logic [7:0]  halt_resume_levels;
	logic [7:0]  fifo_trigger_levels;
	logic [7:0]  xon1;
	logic [7:0]  xon2;
	logic [7:0]  xoff1;
	logic [7:0]  xoff2;
	logic [7:0]  gpio_direction;
	logic [7:0]  iolatch;
	logic [7:0]  ioint;
	logic [7:0]  ioctl;
	logic [7:0]  extra_features_control;
	logic        fifo_en;
	logic [1:0]  txtrig;
	logic [1:0]  rxtrig;
	logic [3:0]  modem_now;
	logic [3:0]  modem_prev;
	logic [3:0]  modem_delta;
	logic [11:0] pins_sync;
	logic [7:0]  gpio_sync;
	logic [3:0]  modem_pin;
	logic        bank_enh;
	logic        bank_div;
	logic        bank_frac;
	logic        bank_lvl;
	logic        ext_en;
	logic        wr_hold;
	logic        rd_hold;
	logic        rd_msr;
	logic [7:0]  next_rdata;
	logic [7:0]  msr_val;
	logic [7:0]  isr_val;
	logic [7:0]  gpio_pin_state_val;

	ucrm_sync #(
		.W(12)
	) u_sync (
		.mclk_i  (mclk_i),
		.resetn_i(resetn_i),
		.async_i ({gpio_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
		.sync_o  (pins_sync)
	);
	assign gpio_sync = pins_sync[11:4];
	assign modem_pin = pins_sync[3:0];

	// bank selection; the host is trusted to leave the key value before normal access
	assign ext_en    = enhanced_function[ucrm_pkg::EFR_EXT_BIT];
	assign bank_enh  = (line_control == ucrm_pkg::LCR_ENH_KEY);
	assign bank_div  = line_control[ucrm_pkg::LCR_DIV_BIT] && !bank_enh;
	assign bank_frac = bank_div && ext_en;
	assign bank_lvl  = modem_control[ucrm_pkg::MCR_TCR_BIT] && !bank_enh;
	assign wr_hold   = wr_i && (addr_i == ucrm_pkg::ADDR_HOLD) && !line_control[ucrm_pkg::LCR_DIV_BIT];
	assign rd_hold   = rd_i && (addr_i == ucrm_pkg::ADDR_HOLD) && !line_control[ucrm_pkg::LCR_DIV_BIT];
	assign rd_msr    = rd_i && (addr_i == ucrm_pkg::ADDR_MSR) && !bank_enh && !bank_lvl;

	// loopback routes the control outputs back onto the status inputs
	always_comb begin
		if (modem_control[ucrm_pkg::MCR_LOOP_BIT]) begin
			modem_now = {modem_control[3], modem_control[2], modem_control[0], modem_control[1]};
		end else begin
			modem_now = ~modem_pin;
		end
	end

	// change flags: a change in the clearing read cycle is kept
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_delta
			always_ff @(posedge mclk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					modem_delta[gi] <= 1'b0;
				end else if (modem_now[gi] != modem_prev[gi]) begin
					modem_delta[gi] <= 1'b1;
				end else if (rd_msr) begin
					modem_delta[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			modem_prev <= '0;
		end else begin
			modem_prev <= modem_now;
		end
	end

	assign msr_val     = {modem_now[3], modem_now[2], modem_now[1], modem_now[0],
	                      modem_delta};
	assign isr_val     = {fifo_en, fifo_en, int_source_i & {2{ext_en}}, int_code_i};
	assign gpio_pin_state_val = (iolatch & gpio_direction) | (gpio_sync & ~gpio_direction);

	// line control, reachable in every bank
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			line_control <= ucrm_pkg::RST_LCR;
		end else if (wr_i && addr_i == ucrm_pkg::ADDR_LCR) begin
			line_control <= wdata_i;
		end
	end

	// divisor and enhanced banks
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dll   <= ucrm_pkg::RST_REG;
			divisor_high   <= ucrm_pkg::RST_REG;
			divisor_fraction   <= ucrm_pkg::RST_REG;
			enhanced_function   <= ucrm_pkg::RST_REG;
			xon1  <= ucrm_pkg::RST_REG;
			xon2  <= ucrm_pkg::RST_REG;
			xoff1 <= ucrm_pkg::RST_REG;
			xoff2 <= ucrm_pkg::RST_REG;
		end else if (wr_i && bank_enh) begin
			case (addr_i)
				ucrm_pkg::ADDR_ISR: enhanced_function   <= wdata_i;
				ucrm_pkg::ADDR_MCR: xon1  <= wdata_i;
				ucrm_pkg::ADDR_LSR: xon2  <= wdata_i;
				ucrm_pkg::ADDR_MSR: xoff1 <= wdata_i;
				ucrm_pkg::ADDR_SPR: xoff2 <= wdata_i;
				default: ;
			endcase
		end else if (wr_i && bank_div) begin
			case (addr_i)
				ucrm_pkg::ADDR_HOLD: dll <= wdata_i;
				ucrm_pkg::ADDR_IER: divisor_high  <= wdata_i;
				ucrm_pkg::ADDR_ISR: begin
					if (bank_frac) begin
						divisor_fraction <= wdata_i;
					end
				end
				default: ;
			endcase
		end
	end

	// normal bank: interrupt enable and modem control, extended bits gated
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			interrupt_enable <= ucrm_pkg::RST_REG;
			modem_control <= ucrm_pkg::RST_REG;
		end else if (wr_i && !bank_enh) begin
			if (addr_i == ucrm_pkg::ADDR_IER && !bank_div) begin
				interrupt_enable <= (wdata_i & ucrm_pkg::MASK_BASE_IER)
				     | ((ext_en ? wdata_i : interrupt_enable) & ucrm_pkg::MASK_EXT_IER);
			end
			if (addr_i == ucrm_pkg::ADDR_MCR) begin
				modem_control <= (wdata_i & ucrm_pkg::MASK_BASE_MCR)
				     | ((ext_en ? wdata_i : modem_control) & ucrm_pkg::MASK_EXT_MCR);
			end
		end
	end

	// fifo control is write-only; resets are one-cycle pulses
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fifo_en         <= 1'b0;
			txtrig          <= ucrm_pkg::RST_TRIG;
			rxtrig          <= ucrm_pkg::RST_TRIG;
			rx_fifo_reset_o <= 1'b0;
			tx_fifo_reset_o <= 1'b0;
		end else begin
			rx_fifo_reset_o <= 1'b0;
			tx_fifo_reset_o <= 1'b0;
			if (wr_i && addr_i == ucrm_pkg::ADDR_ISR && !line_control[ucrm_pkg::LCR_DIV_BIT]) begin
				fifo_en         <= wdata_i[ucrm_pkg::FCR_EN_BIT];
				rx_fifo_reset_o <= wdata_i[ucrm_pkg::FCR_RXR_BIT];
				tx_fifo_reset_o <= wdata_i[ucrm_pkg::FCR_TXR_BIT];
				rxtrig          <= wdata_i[7:6];
				if (ext_en) begin
					txtrig <= wdata_i[5:4];
				end
			end
		end
	end

	// scratch and level registers share locations 6 and 7
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			scratch_pad <= ucrm_pkg::RST_REG;
			halt_resume_levels <= ucrm_pkg::RST_REG;
			fifo_trigger_levels <= ucrm_pkg::RST_REG;
		end else if (wr_i && !bank_enh) begin
			if (addr_i == ucrm_pkg::ADDR_MSR && bank_lvl) begin
				halt_resume_levels <= wdata_i;
			end
			if (addr_i == ucrm_pkg::ADDR_SPR) begin
				if (bank_lvl) begin
					fifo_trigger_levels <= wdata_i;
				end else begin
					scratch_pad <= wdata_i;
				end
			end
		end
	end

	// upper block is bank independent; 0x08, 0x09 and 0x0d ignore writes
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gpio_direction   <= ucrm_pkg::RST_REG;
			iolatch <= ucrm_pkg::RST_REG;
			ioint   <= ucrm_pkg::RST_REG;
			ioctl   <= ucrm_pkg::RST_REG;
			extra_features_control    <= ucrm_pkg::RST_REG;
		end else if (wr_i) begin
			case (addr_i)
				ucrm_pkg::ADDR_GPIO_DIRECTION:   gpio_direction   <= wdata_i;
				ucrm_pkg::ADDR_GPIO_PIN_STATE: iolatch <= wdata_i;
				ucrm_pkg::ADDR_IOINT:   ioint   <= wdata_i;
				ucrm_pkg::ADDR_IOCTL:   ioctl   <= wdata_i & ucrm_pkg::MASK_IOCTL;
				ucrm_pkg::ADDR_EXTRA_FEATURES_CONTROL:    extra_features_control    <= wdata_i & ucrm_pkg::MASK_EXTRA_FEATURES_CONTROL;
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		next_rdata = 8'h00;
		case (addr_i)
			ucrm_pkg::ADDR_HOLD: begin
				next_rdata = line_control[ucrm_pkg::LCR_DIV_BIT] ? dll : rx_data_i;
			end
			ucrm_pkg::ADDR_IER: begin
				next_rdata = line_control[ucrm_pkg::LCR_DIV_BIT] ? divisor_high : interrupt_enable;
			end
			ucrm_pkg::ADDR_ISR: begin
				if (bank_enh) begin
					next_rdata = enhanced_function;
				end else if (bank_frac) begin
					next_rdata = divisor_fraction;
				end else begin
					next_rdata = isr_val;
				end
			end
			ucrm_pkg::ADDR_LCR: next_rdata = line_control;
			ucrm_pkg::ADDR_MCR: next_rdata = bank_enh ? xon1 : modem_control;
			ucrm_pkg::ADDR_LSR: next_rdata = bank_enh ? xon2 : line_status_i;
			ucrm_pkg::ADDR_MSR: begin
				if (bank_enh) begin
					next_rdata = xoff1;
				end else begin
					next_rdata = bank_lvl ? halt_resume_levels : msr_val;
				end
			end
			ucrm_pkg::ADDR_SPR: begin
				if (bank_enh) begin
					next_rdata = xoff2;
				end else begin
					next_rdata = bank_lvl ? fifo_trigger_levels : scratch_pad;
				end
			end
			ucrm_pkg::ADDR_TX_FILL_COUNT: next_rdata = {1'b0, tx_level_i};
			ucrm_pkg::ADDR_RX_FILL_COUNT: next_rdata = {1'b0, rx_level_i};
			ucrm_pkg::ADDR_GPIO_DIRECTION:   next_rdata = gpio_direction;
			ucrm_pkg::ADDR_GPIO_PIN_STATE: next_rdata = gpio_pin_state_val;
			ucrm_pkg::ADDR_IOINT:   next_rdata = ioint;
			ucrm_pkg::ADDR_RSVD:    next_rdata = 8'h00;
			ucrm_pkg::ADDR_IOCTL:   next_rdata = ioctl;
			ucrm_pkg::ADDR_EXTRA_FEATURES_CONTROL:    next_rdata = extra_features_control;
			default: next_rdata = 8'h00;
		endcase
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= rd_i ? next_rdata : 8'h00;
		end
	end

	// holding register side effects
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_pop_o  <= 1'b0;
			tx_push_o <= 1'b0;
			tx_data_o <= 8'h00;
		end else begin
			rx_pop_o  <= rd_hold;
			tx_push_o <= wr_hold;
			if (wr_hold) begin
				tx_data_o <= wdata_i;
			end
		end
	end

	// registered outputs; extended fields are hidden while the enable is clear
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fifo_enable_o            <= 1'b0;
			tx_trig_sel_o            <= ucrm_pkg::RST_TRIG;
			rx_trig_sel_o            <= ucrm_pkg::RST_TRIG;
			line_control_o           <= ucrm_pkg::RST_LCR;
			divisor_o                <= 16'h0000;
			divisor_fraction_o       <= ucrm_pkg::RST_REG;
			enhanced_function_o      <= ucrm_pkg::RST_REG;
			interrupt_enable_o       <= ucrm_pkg::RST_REG;
			modem_control_o          <= ucrm_pkg::RST_REG;
			halt_resume_levels_o     <= ucrm_pkg::RST_REG;
			fifo_trigger_levels_o    <= ucrm_pkg::RST_REG;
			flow_chars_o             <= 32'h00000000;
			gpio_irq_enable_o        <= ucrm_pkg::RST_REG;
			gpio_control_o           <= ucrm_pkg::RST_REG;
			extra_features_control_o <= ucrm_pkg::RST_REG;
			dtr_n_o                  <= 1'b1;
			rts_n_o                  <= 1'b1;
			gpio_o                   <= 8'h00;
			gpio_oe_o                <= 8'h00;
		end else begin
			fifo_enable_o            <= fifo_en;
			tx_trig_sel_o            <= ext_en ? txtrig : ucrm_pkg::RST_TRIG;
			rx_trig_sel_o            <= rxtrig;
			line_control_o           <= line_control;
			divisor_o                <= {divisor_high, dll};
			divisor_fraction_o       <= ext_en ? divisor_fraction : ucrm_pkg::RST_REG;
			enhanced_function_o      <= enhanced_function;
			interrupt_enable_o       <= interrupt_enable & (ext_en ? 8'hff : ucrm_pkg::MASK_BASE_IER);
			modem_control_o          <= modem_control & (ext_en ? 8'hff : ucrm_pkg::MASK_BASE_MCR);
			halt_resume_levels_o     <= halt_resume_levels;
			fifo_trigger_levels_o    <= fifo_trigger_levels;
			flow_chars_o             <= {xoff2, xoff1, xon2, xon1};
			gpio_irq_enable_o        <= ioint;
			gpio_control_o           <= ioctl;
			extra_features_control_o <= extra_features_control;
			// pins hold their last driven level during loopback
			if (!modem_control[ucrm_pkg::MCR_LOOP_BIT]) begin
				dtr_n_o <= ~modem_control[0];
				rts_n_o <= ~modem_control[1];
			end
			gpio_o                   <= iolatch;
			gpio_oe_o                <= gpio_direction;
		end
	end
endmodule // ucrm_regs

// ---- bench/ucrm_far.sv ----
// ucrm_far: behavioural fifo side facing the register map.
// assumes pops and pushes are one-cycle pulses on mclk_i.
`timescale 1ns/1ps
module ucrm_far (
	// clock and reset
	input  wire logic       mclk_i,
	input  wire logic       resetn_i,
	// register map side
	input  wire logic       rx_pop_i,
	input  wire logic       tx_push_i,
	output logic      [7:0] rx_data_o,
	output logic      [6:0] tx_level_o,
	output logic      [6:0] rx_level_o,
	output logic      [7:0] line_status_o
);
	// receive queue preloaded with eight bytes counting up from 8'ha0
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rx_data_o <= 8'ha0;
			rx_level_o <= 7'h08;
		end else if (rx_pop_i && rx_level_o != 7'h00) begin
			rx_data_o <= rx_data_o + 8'h01;
			rx_level_o <= rx_level_o - 7'h01;
		end
	end
	// no transmitter drains it, so the count only shows pushes
	always @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_level_o <= 7'h00;
		end else if (tx_push_i) begin
			tx_level_o <= tx_level_o + 7'h01;
		end
	end
	assign line_status_o = {1'b0, {2{tx_level_o == 7'h00}}, 4'h0, rx_level_o != 7'h00};
endmodule // ucrm_far

// ---- bench/ucrm_regs_chk.sv ----
// ucrm_regs_chk: port-level assertions for the channel register map.
// assumes it is bound to ucrm_regs and sees its ports only.
`timescale 1ns/1ps
module ucrm_regs_chk (
	// clock, reset and bus
	input wire logic       mclk_i,
	input wire logic       resetn_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	// watched side
	input wire logic [7:0] rx_data_i,
	input wire logic       rx_pop_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       tx_push_o,
	input wire logic [6:0] tx_level_i,
	input wire logic [6:0] rx_level_i,
	input wire logic [7:0] line_status_i,
	input wire logic       rx_fifo_reset_o,
	input wire logic       tx_fifo_reset_o,
	input wire logic [1:0] tx_trig_sel_o,
	input wire logic [7:0] line_control_o,
	input wire logic [7:0] divisor_fraction_o,
	input wire logic [7:0] enhanced_function_o,
	input wire logic [7:0] interrupt_enable_o,
	input wire logic [7:0] modem_control_o,
	input wire logic       dtr_n_o,
	input wire logic       rts_n_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!resetn_i);
	// line_control_o lags its register, so skip the cycle after a write
	AST_HOLD_POP: assert property (
		rd_i && addr_i == 4'h0 && !line_control_o[7] && !$past(wr_i)
		|=> rx_pop_o && rdata_o == $past(rx_data_i)) else $error("holding read lost");
	AST_HOLD_PUSH: assert property (
		wr_i && addr_i == 4'h0 && !line_control_o[7] && !$past(wr_i)
		|=> tx_push_o && tx_data_o == $past(wdata_i)) else $error("holding write lost");
	AST_POP_CAUSE: assert property (
		rx_pop_o |-> $past(rd_i) && $past(addr_i) == 4'h0) else $error("stray pop");
	AST_TX_LEVEL: assert property (
		rd_i && addr_i == 4'h8 |=> rdata_o == {1'b0, $past(tx_level_i)}) else $error("tx level");
	AST_RX_LEVEL: assert property (
		rd_i && addr_i == 4'h9 |=> rdata_o == {1'b0, $past(rx_level_i)}) else $error("rx level");
	AST_RESERVED: assert property (
		rd_i && addr_i == 4'hd |=> rdata_o == 8'h00) else $error("reserved not zero");
	AST_LINE_STATUS: assert property (
		rd_i && addr_i == 4'h5 && line_control_o != ucrm_pkg::LCR_ENH_KEY && !$past(wr_i)
		|=> rdata_o == $past(line_status_i)) else $error("line status");
	AST_EXT_MASK: assert property (
		!enhanced_function_o[4] |-> interrupt_enable_o[7:4] == 4'h0
		&& modem_control_o[7:5] == 3'h0 && divisor_fraction_o == 8'h00
		&& tx_trig_sel_o == 2'h0) else $error("extended field leaked");
	AST_FIFO_RESET: assert property (
		rx_fifo_reset_o |-> $past(wr_i && addr_i == 4'h2 && wdata_i[1])) else $error("fifo reset");
	AST_TX_FIFO_RESET: assert property (
		tx_fifo_reset_o |-> $past(wr_i && addr_i == 4'h2 && wdata_i[2])) else $error("tx fifo reset");
	AST_FIFO_PULSE: assert property (
		wr_i && addr_i == 4'h2 && !line_control_o[7] && !$past(wr_i)
		|=> rx_fifo_reset_o == $past(wdata_i[1]) && tx_fifo_reset_o == $past(wdata_i[2]))
		else $error("fifo reset pulse missing");
	AST_MODEM_PINS: assert property (
		!modem_control_o[4] && $stable(modem_control_o)
		|-> dtr_n_o == !modem_control_o[0] && rts_n_o == !modem_control_o[1])
		else $error("modem pins");
endmodule // ucrm_regs_chk
bind ucrm_regs ucrm_regs_chk u_ucrm_regs_chk (.*);

// ---- bench/ucrm_regs_tb.sv ----
// ucrm_regs_tb: directed register map scenarios with a fifo-side model.
// assumes ucrm_regs on a 40 MHz mclk_i with active-low asynchronous reset.
`timescale 1ns/1ps
module ucrm_regs_tb;
	logic        mclk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic  [3:0] addr_i = 4'h0;
	logic  [7:0] wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic  [3:0] int_code_i = 4'h6;
	logic  [1:0] int_source_i = 2'h3;
	logic  [3:0] pins_n = 4'hf;
	logic  [7:0] gpio_i = 8'h3c;
	logic  [7:0] rdata_o, rx_data_i, tx_data_o, line_status_i, fifo_trigger_levels_o;
	logic  [7:0] gpio_o, gpio_oe_o;
	logic  [7:0] halt_resume_levels_o, gpio_irq_enable_o, gpio_control_o;
	logic  [7:0] extra_features_control_o;
	logic  [6:0] tx_level_i, rx_level_i;
	logic  [1:0] tx_trig_sel_o, rx_trig_sel_o;
	logic [15:0] divisor_o;
	logic [31:0] flow_chars_o;
	logic        rx_pop_o, tx_push_o, fifo_enable_o, dtr_n_o, rts_n_o;
	logic  [7:0] got;
	int          n_errors = 0;
	int          comparisons = 0;

	ucrm_regs u_ucrm_regs (.mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.rx_data_i(rx_data_i), .rx_pop_o(rx_pop_o), .tx_data_o(tx_data_o),
		.tx_push_o(tx_push_o), .tx_level_i(tx_level_i), .rx_level_i(rx_level_i),
		.int_code_i(int_code_i), .int_source_i(int_source_i),
		.line_status_i(line_status_i), .fifo_enable_o(fifo_enable_o),
		.rx_fifo_reset_o(), .tx_fifo_reset_o(), .tx_trig_sel_o(tx_trig_sel_o),
		.rx_trig_sel_o(rx_trig_sel_o), .line_control_o(), .divisor_o(divisor_o),
		.divisor_fraction_o(), .enhanced_function_o(), .interrupt_enable_o(),
		.modem_control_o(), .halt_resume_levels_o(halt_resume_levels_o),
		.fifo_trigger_levels_o(fifo_trigger_levels_o), .flow_chars_o(flow_chars_o),
		.gpio_irq_enable_o(gpio_irq_enable_o), .gpio_control_o(gpio_control_o),
		.extra_features_control_o(extra_features_control_o),
		.cts_n_i(pins_n[0]), .dsr_n_i(pins_n[1]), .ri_n_i(pins_n[2]), .cd_n_i(pins_n[3]),
		.dtr_n_o(dtr_n_o), .rts_n_o(rts_n_o), .gpio_i(gpio_i), .gpio_o(gpio_o),
		.gpio_oe_o(gpio_oe_o));
	ucrm_far u_ucrm_far (.mclk_i(mclk_i), .resetn_i(resetn_i), .rx_pop_i(rx_pop_o),
		.tx_push_i(tx_push_o), .rx_data_o(rx_data_i), .tx_level_o(tx_level_i),
		.rx_level_o(rx_level_i), .line_status_o(line_status_i));

	always #12.5 mclk_i = ~mclk_i;

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 got = rdata_o;
	endtask
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
		rd(a);
		chk(what, exp, got);
	endtask
	// outputs follow a write by two edges
	task automatic settle();
		repeat (2) @(posedge mclk_i);
		#1;
	endtask

	task automatic t_reset();
		rdc(4'h3, ucrm_pkg::RST_LCR, "lcr reset");
		rdc(4'h7, ucrm_pkg::RST_REG, "spr reset");
		chk("dtr reset", 1'b1, dtr_n_o);
	endtask
	task automatic t_base();
		wr(4'h1, 8'hff);
		rdc(4'h1, 8'h0f, "ier base");
		wr(4'h2, 8'hf7);
		rdc(4'h2, 8'hc6, "isr base");
		settle();
		chk("fcr", 5'b11100, {fifo_enable_o, rx_trig_sel_o, tx_trig_sel_o});
	endtask
	task automatic t_hold();
		wr(4'h3, 8'h03);
		wr(4'h0, 8'h5a);
		#1 chk("tx data", 8'h5a, tx_data_o);
		rdc(4'h0, 8'ha0, "rx first");
		rdc(4'h0, 8'ha1, "rx second");
	endtask
	task automatic t_div();
		wr(4'h3, 8'h83);
		wr(4'h0, 8'h34);
		wr(4'h1, 8'h12);
		rdc(4'h0, 8'h34, "dll");
		rdc(4'h3, 8'h83, "lcr");
		settle();
		chk("divisor", 16'h1234, divisor_o);
	endtask
	task automatic t_enh();
		wr(4'h3, ucrm_pkg::LCR_ENH_KEY);
		wr(4'h2, 8'h10);
		for (int i = 0; i < 4; i++) begin
			wr(4'(4 + i), 8'(17 * (i + 1)));
		end
		rdc(4'h7, 8'h44, "xoff2");
		settle();
		chk("flow chars", 32'h44332211, flow_chars_o);
		wr(4'h3, 8'h80);
		wr(4'h2, 8'h07);
		rdc(4'h2, 8'h07, "fraction");
		wr(4'h3, 8'h03);
		wr(4'h1, 8'hf5);
		rdc(4'h1, 8'hf5, "ier ext");
		rdc(4'h2, 8'hf6, "isr ext");
	endtask
	task automatic t_lvl();
		wr(4'h4, 8'h04);
		wr(4'h6, 8'ha5);
		wr(4'h7, 8'h5a);
		rdc(4'h6, 8'ha5, "halt levels");
		settle();
		chk("trig levels", 8'h5a, fifo_trigger_levels_o);
		chk("halt levels out", 8'ha5, halt_resume_levels_o);
		wr(4'h4, 8'h03);
		wr(4'h7, 8'h3c);
		rdc(4'h7, 8'h3c, "scratch");
		settle();
		chk("modem pins", 2'b00, {dtr_n_o, rts_n_o});
	endtask
	task automatic t_msr();
		// a first read drops any earlier change flags
		rd(4'h6);
		@(posedge mclk_i);
		pins_n <= 4'he;
		repeat (4) @(posedge mclk_i);
		rdc(4'h6, 8'h11, "msr delta");
		rdc(4'h6, 8'h10, "msr state");
		// loopback: states follow control bits, pins stay where they were
		wr(4'h4, 8'h10);
		rdc(4'h6, 8'h01, "msr loopback");
		chk("loopback pins", 2'b00, {dtr_n_o, rts_n_o});
	endtask
	task automatic t_ro();
		wr(4'h8, 8'hff);
		wr(4'h9, 8'hff);
		wr(4'hd, 8'hff);
		rdc(4'h8, 8'h01, "tx level");
		rdc(4'h9, 8'h06, "rx level");
		rdc(4'hd, 8'h00, "reserved");
		rdc(4'h5, 8'h01, "line status");
	endtask
	task automatic t_gpio();
		wr(4'ha, 8'hf0);
		wr(4'hb, 8'ha5);
		wr(4'hc, 8'h0f);
		wr(4'he, 8'hff);
		wr(4'hf, 8'hff);
		rdc(4'ha, 8'hf0, "gpio dir");
		rdc(4'hb, 8'hac, "gpio state");
		rdc(4'hc, 8'h0f, "gpio irq");
		rdc(4'he, ucrm_pkg::MASK_IOCTL, "io control");
		rdc(4'hf, ucrm_pkg::MASK_EXTRA_FEATURES_CONTROL, "extra features");
		chk("gpio drive", 16'hf0a5, {gpio_oe_o, gpio_o});
		chk("gpio irq out", 8'h0f, gpio_irq_enable_o);
		chk("io control out", ucrm_pkg::MASK_IOCTL, gpio_control_o);
		chk("extra features out", ucrm_pkg::MASK_EXTRA_FEATURES_CONTROL, extra_features_control_o);
	endtask

	task automatic conclude();
		if (n_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_base();
		t_hold();
		t_div();
		t_enh();
		t_lvl();
		t_msr();
		t_ro();
		t_gpio();
		conclude();
	end
	// the whole sequence needs about 140 cycles
	initial begin
		repeat (3000) @(posedge mclk_i);
		n_errors++;
		conclude();
	end
endmodule // ucrm_regs_tb
